// ---- design/fdx_pkg.sv ----
// Package for the floppy FIFO, DMA and result-phase control block.
// Assumes a single 200 MHz clock domain and synchronous active-high reset.
package fdx_pkg;
  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int FDX_FIFO_DEPTH = 16;
  localparam logic [3:0] FDX_THR_RST = 4'h0;
  localparam logic FDX_FIFO_DIS_RST = 1'b1;
  localparam logic [7:0] FDX_DTL_NONE = 8'hFF;
  localparam logic [2:0] FDX_SIZE_128 = 3'h0;
  localparam int FDX_SIZE_128_BYTES = 128;
  // ----------------------------------------------------------------
  // Command codes and result values
  // ----------------------------------------------------------------
  localparam logic [4:0] FDX_CMD_READ = 5'h06;
  localparam logic [4:0] FDX_CMD_WRITE = 5'h05;
  localparam logic [4:0] FDX_CMD_VERIFY = 5'h16;
  localparam logic [4:0] FDX_CMD_SENSE_INT = 5'h08;
  localparam logic [4:0] FDX_CMD_SPECIFY = 5'h03;
  localparam logic [4:0] FDX_CMD_CONFIGURE = 5'h13;
  localparam logic [4:0] FDX_CMD_PERP = 5'h12;
  localparam logic [4:0] FDX_CMD_REL_SEEK = 5'h0F;
  localparam logic [7:0] FDX_ST0_INVALID = 8'h80;
  localparam logic [7:0] FDX_ST0_ABNORMAL = 8'h40;
  localparam logic [7:0] FDX_ST0_NORMAL = 8'h00;
  localparam logic [2:0] FDX_RES_BYTES_XFER = 3'h3;
  localparam logic [2:0] FDX_RES_BYTES_SENSE = 3'h1;
  // ----------------------------------------------------------------
  // Phases of the controller
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FDX_IDLE, FDX_EXEC, FDX_FINISH, FDX_RESULT
  } fdx_phase_t;
  // Valid-command decode used by the phase logic.
  function automatic logic fdx_cmd_valid(input logic [4:0] c);
    case (c)
      FDX_CMD_READ, FDX_CMD_WRITE, FDX_CMD_VERIFY, FDX_CMD_SENSE_INT,
      FDX_CMD_SPECIFY, FDX_CMD_CONFIGURE, FDX_CMD_PERP,
      FDX_CMD_REL_SEEK: fdx_cmd_valid = 1'b1;
      default: fdx_cmd_valid = 1'b0;
    endcase
  endfunction
endpackage

// ---- design/fdx_sync.sv ----
// Two-flop synchroniser for a single level from outside the clock domain.
// Assumes the source is a pin that may change at any time.
`timescale 1ns/1ps
module fdx_sync import fdx_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Asynchronous level in, synchronised level out.
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  // The first flop feeds only the second one.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ---- design/fdx_fifo.sv ----
// Sixteen-byte data FIFO between the DMA side and the disk side.
// Assumes both sides run on clk; the caller never pushes when full or pops when empty.
`timescale 1ns/1ps
module fdx_fifo import fdx_pkg::*; #(
  parameter int DEPTH = FDX_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // Write side.
  input wire logic push,
  input wire logic [7:0] wdata,
  // Read side.
  input wire logic pop,
  output logic [7:0] rdata,
  // Fill level.
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  // Storage is written without reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wdata;
    end
  end
  // Pointers and count.
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wp_q <= '0;
      rp_q <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  assign rdata = mem[rp_q];
endmodule

// ---- design/fdx_ctrl.sv ----
// Floppy controller FIFO/DMA flow control and result-phase control.
// Assumes the command decoder delivers command and parameter bytes as strobes,
// the disk side streams bytes with strobes, and DMA pins are synchronised here.
`timescale 1ns/1ps
module fdx_ctrl import fdx_pkg::*; #(
  parameter int DEPTH = FDX_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Command decoder: first byte and parameter bytes already gathered.
  input wire logic cmd_stb,
  input wire logic [4:0] cmd_code,
  input wire logic [7:0] cmd_cylinder,
  input wire logic [7:0] cmd_final_sector_number,
  input wire logic [7:0] cmd_start_sector,
  input wire logic [2:0] cmd_size_code,
  input wire logic [7:0] cmd_special_byte_length,
  input wire logic cmd_enable_sector_count,
  input wire logic cmd_dir_in,
  input wire logic [1:0] cmd_perpendicular_drive_bits,
  input wire logic cmd_fifo_disable_n,
  input wire logic [3:0] cmd_fifo_threshold_param,
  input wire logic cmd_dma_enable,
  // DMA pins from the system DMA controller.
  input wire logic dma_ack_n,
  input wire logic dma_rd_n,
  input wire logic dma_wr_n,
  input wire logic terminal_count,
  input wire logic [7:0] dma_wdata,
  output logic dma_req,
  output logic [7:0] dma_rdata,
  // Disk side byte stream.
  input wire logic disk_rd_stb,
  input wire logic [7:0] disk_rd_data,
  input wire logic disk_wr_stb,
  input wire logic disk_sector_end,
  output logic [7:0] disk_wr_data,
  // Host status and result port.
  input wire logic result_rd_stb,
  output logic [7:0] result_data,
  output logic request_for_master_flag,
  output logic transfer_direction_flag,
  output logic controller_busy_flag,
  output logic irq,
  // Configuration state shown to the drive logic.
  output logic [7:0] cylinder_q,
  output logic [7:0] sectors_per_track_q,
  output logic [1:0] perpendicular_drives_q,
  output logic step_inward_q,
  output logic fifo_disable_n_q,
  output logic [3:0] fifo_threshold_param_q
);
  localparam int CW = $clog2(DEPTH) + 1;
  initial begin
    if (DEPTH != FDX_FIFO_DEPTH) $error("FIFO depth must match threshold range");
  end
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic ack_s, rd_s, wr_s, tc_s;
  fdx_sync u_s_ack (.clk(clk), .rst(rst), .async_in(~dma_ack_n), .sync_out(ack_s));
  fdx_sync u_s_rd (.clk(clk), .rst(rst), .async_in(~dma_rd_n), .sync_out(rd_s));
  fdx_sync u_s_wr (.clk(clk), .rst(rst), .async_in(~dma_wr_n), .sync_out(wr_s));
  fdx_sync u_s_tc (.clk(clk), .rst(rst), .async_in(terminal_count), .sync_out(tc_s));
  logic rd_prev_q, wr_prev_q;
  logic dma_rd_cyc, dma_wr_cyc;
  // A DMA cycle counts once, on the end of its strobe, with acknowledge held.
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_s & ack_s;
      wr_prev_q <= wr_s & ack_s;
    end
  end
  assign dma_rd_cyc = rd_prev_q & ~(rd_s & ack_s);
  assign dma_wr_cyc = wr_prev_q & ~(wr_s & ack_s);
  // ----------------------------------------------------------------
  // Phase and transfer state
  // ----------------------------------------------------------------
  fdx_phase_t phase_q;
  logic to_host_q, tc_seen_q, abnormal_q, invalid_q, dma_on_q;
  logic [7:0] sector_q, bytes_q, limit_q;
  logic [2:0] res_left_q;
  logic [7:0] st0_q;
  logic [CW-1:0] count;
  logic [7:0] fifo_out;
  logic xfer_cmd, push, pop, full, empty, host_idle_end;
  assign xfer_cmd = (cmd_code == FDX_CMD_READ) || (cmd_code == FDX_CMD_WRITE);
  assign full = (count == CW'(DEPTH));
  assign empty = (count == '0);
  // Only DMA cycles touch the FIFO on the host side.
  assign push = to_host_q ? (disk_rd_stb && !full && bytes_q < limit_q)
                          : (dma_wr_cyc && !full && !tc_seen_q);
  assign pop = to_host_q ? (dma_rd_cyc && !empty) : (disk_wr_stb && !empty);
  // Host starved the FIFO mid-sector: underrun or overrun.
  assign host_idle_end = to_host_q ? (disk_rd_stb && full) : (disk_wr_stb && empty && !tc_seen_q);
  fdx_fifo #(.DEPTH(DEPTH)) u_fifo (
    .clk(clk), .rst(rst), .flush(phase_q == FDX_IDLE),
    .push(push), .wdata(to_host_q ? disk_rd_data : dma_wdata),
    .pop(pop), .rdata(fifo_out), .count(count)
  );
  // Configuration commands; cylinder takes any byte value.
  always_ff @(posedge clk) begin
    if (rst) begin
      cylinder_q <= 8'h00;
      sectors_per_track_q <= 8'h00;
      perpendicular_drives_q <= 2'h0;
      step_inward_q <= 1'b0;
      fifo_disable_n_q <= FDX_FIFO_DIS_RST;
      fifo_threshold_param_q <= FDX_THR_RST;
      dma_on_q <= 1'b0;
    end else if (cmd_stb && phase_q == FDX_IDLE) begin
      case (cmd_code)
        FDX_CMD_CONFIGURE: begin
          fifo_disable_n_q <= cmd_fifo_disable_n;
          fifo_threshold_param_q <= cmd_fifo_threshold_param;
        end
        FDX_CMD_SPECIFY: dma_on_q <= cmd_dma_enable;
        FDX_CMD_PERP: perpendicular_drives_q <= cmd_perpendicular_drive_bits;
        FDX_CMD_REL_SEEK: step_inward_q <= cmd_dir_in;
        FDX_CMD_VERIFY: begin
          if (cmd_enable_sector_count) begin
            sectors_per_track_q <= cmd_special_byte_length;
          end
        end
        default: cylinder_q <= xfer_cmd ? cmd_cylinder : cylinder_q;
      endcase
    end
  end
  // Phase machine: execution, sector finishing, result phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= FDX_IDLE;
      to_host_q <= 1'b0;
      tc_seen_q <= 1'b0;
      abnormal_q <= 1'b0;
      invalid_q <= 1'b0;
      sector_q <= 8'h00;
      bytes_q <= 8'h00;
      limit_q <= 8'h00;
      res_left_q <= 3'h0;
      st0_q <= FDX_ST0_NORMAL;
    end else begin
      case (phase_q)
        FDX_IDLE: begin
          if (cmd_stb) begin
            if (!fdx_cmd_valid(cmd_code)) begin
              invalid_q <= 1'b1;
              phase_q <= FDX_RESULT;
              res_left_q <= 3'h0;
            end else if (cmd_code == FDX_CMD_SENSE_INT) begin
              st0_q <= invalid_q ? FDX_ST0_INVALID : st0_q;
              invalid_q <= 1'b0;
              res_left_q <= FDX_RES_BYTES_SENSE;
              phase_q <= FDX_RESULT;
            end else if (xfer_cmd && dma_on_q) begin
              to_host_q <= (cmd_code == FDX_CMD_READ);
              sector_q <= cmd_start_sector;
              bytes_q <= 8'h00;
              // Short sectors pass only the special length to the host.
              limit_q <= (cmd_size_code == FDX_SIZE_128) ? cmd_special_byte_length
                                                         : FDX_DTL_NONE;
              tc_seen_q <= 1'b0;
              abnormal_q <= 1'b0;
              phase_q <= FDX_EXEC;
            end
          end
        end
        FDX_EXEC: begin
          if (tc_s) begin
            tc_seen_q <= 1'b1;
          end
          if (host_idle_end) begin
            abnormal_q <= 1'b1;
            phase_q <= FDX_FINISH;
            // Marks a write cut mid-sector so the finish step waits for the sector end.
            bytes_q <= to_host_q ? bytes_q : (bytes_q | 8'h01);
          end else if (disk_sector_end) begin
            bytes_q <= 8'h00;
            sector_q <= sector_q + 8'h01;
            if (tc_seen_q || tc_s) begin
              phase_q <= FDX_FINISH;
            end else if (sector_q == cmd_final_sector_number) begin
              abnormal_q <= 1'b1;
              phase_q <= FDX_FINISH;
            end
          end else if ((to_host_q && disk_rd_stb) || (!to_host_q && disk_wr_stb)) begin
            bytes_q <= (bytes_q == 8'hFF) ? bytes_q : bytes_q + 8'h01;
          end
        end
        FDX_FINISH: begin
          // The disk side completes the sector; extra bytes are dropped or zero.
          // A write that stopped on a sector boundary has nothing left to finish.
          if (disk_sector_end || (to_host_q ? empty : bytes_q == 8'h00)) begin
            st0_q <= abnormal_q ? FDX_ST0_ABNORMAL : FDX_ST0_NORMAL;
            res_left_q <= FDX_RES_BYTES_XFER;
            phase_q <= FDX_RESULT;
          end
        end
        FDX_RESULT: begin
          if (result_rd_stb && res_left_q != 3'h0) begin
            res_left_q <= res_left_q - 3'h1;
          end
          if (res_left_q == 3'h0 && !invalid_q) begin
            phase_q <= FDX_IDLE;
          end else if (res_left_q == 3'h0 && cmd_stb && cmd_code == FDX_CMD_SENSE_INT) begin
            st0_q <= FDX_ST0_INVALID;
            invalid_q <= 1'b0;
            res_left_q <= FDX_RES_BYTES_SENSE;
          end
        end
        default: phase_q <= FDX_IDLE;
      endcase
    end
  end
  // DMA request: threshold raises it, and sector end too when reading; empty or full drop it.
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_req <= 1'b0;
    end else if (phase_q != FDX_EXEC && !(phase_q == FDX_FINISH && to_host_q)) begin
      dma_req <= 1'b0;
    end else if (to_host_q) begin
      if (empty || (pop && count == CW'(1))) begin
        dma_req <= 1'b0;
      end else if (count >= CW'(DEPTH) - CW'(fifo_threshold_param_q) - CW'(1)
                   || disk_sector_end || phase_q == FDX_FINISH) begin
        dma_req <= 1'b1;
      end
    end else if (tc_seen_q || tc_s) begin
      dma_req <= 1'b0;
    end else if (full || (push && count == CW'(DEPTH - 1))) begin
      dma_req <= 1'b0;
    end else if (!dma_req && (bytes_q == 8'h00 && count == '0
                 || count <= CW'(fifo_threshold_param_q) + CW'(1))) begin
      dma_req <= 1'b1;
    end
  end
  // Data outputs and status flags for polling software.
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_rdata <= 8'h00;
      disk_wr_data <= 8'h00;
      result_data <= 8'h00;
      request_for_master_flag <= 1'b1;
      transfer_direction_flag <= 1'b0;
      controller_busy_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      dma_rdata <= fifo_out;
      // Write remainder beyond the special length is zero filled.
      disk_wr_data <= (empty || bytes_q >= limit_q) ? 8'h00 : fifo_out;
      result_data <= st0_q;
      request_for_master_flag <= (phase_q == FDX_IDLE) || (phase_q == FDX_RESULT);
      transfer_direction_flag <= (phase_q == FDX_RESULT) && res_left_q != 3'h0;
      controller_busy_flag <= (phase_q != FDX_IDLE);
      irq <= (phase_q == FDX_RESULT) && (res_left_q != 3'h0 || invalid_q);
    end
  end
endmodule

// ---- verif/fdx_ctrl_properties.sv ----
// Property checker for the floppy FIFO, DMA and result-phase control block.
// Assumes it is bound to fdx_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module fdx_ctrl_properties import fdx_pkg::*; #(
  parameter int DEPTH = FDX_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Command inputs.
  input wire logic cmd_stb,
  input wire logic [4:0] cmd_code,
  input wire logic cmd_dma_enable,
  input wire logic cmd_fifo_disable_n,
  input wire logic [3:0] cmd_fifo_threshold_param,
  input wire logic [1:0] cmd_perpendicular_drive_bits,
  input wire logic cmd_dir_in,
  // DMA pins and host status.
  input wire logic terminal_count,
  input wire logic result_rd_stb,
  input wire logic dma_req,
  input wire logic request_for_master_flag,
  input wire logic transfer_direction_flag,
  input wire logic controller_busy_flag,
  input wire logic irq,
  // Configuration outputs.
  input wire logic fifo_disable_n_q,
  input wire logic [3:0] fifo_threshold_param_q,
  input wire logic [1:0] perpendicular_drives_q,
  input wire logic step_inward_q
);
  default clocking dflt @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic idle, ok_code, dma_en_q, last_rw_q, tc_armed_q;
  logic [3:0] tc_cnt_q;
  // Idle means ready for a command byte; ok_code is the accepted code list.
  assign idle = request_for_master_flag && !transfer_direction_flag && !controller_busy_flag;
  assign ok_code = cmd_code inside {FDX_CMD_READ, FDX_CMD_WRITE, FDX_CMD_VERIFY,
    FDX_CMD_SENSE_INT, FDX_CMD_SPECIFY, FDX_CMD_CONFIGURE, FDX_CMD_PERP, FDX_CMD_REL_SEEK};
  // Tracks the DMA enable and whether the last accepted command moves data.
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_en_q <= 1'b0;
      last_rw_q <= 1'b0;
    end else if (cmd_stb && idle) begin
      last_rw_q <= (cmd_code == FDX_CMD_READ) || (cmd_code == FDX_CMD_WRITE);
      if (cmd_code == FDX_CMD_SPECIFY) dma_en_q <= cmd_dma_enable;
    end
  end
  // Counts cycles since terminal count was last seen, until the next command.
  always_ff @(posedge clk) begin
    if (rst || cmd_stb) begin
      tc_armed_q <= 1'b0;
      tc_cnt_q <= 4'h0;
    end else if (terminal_count) begin
      tc_armed_q <= 1'b1;
      tc_cnt_q <= 4'h0;
    end else if (tc_cnt_q != 4'hF) begin
      tc_cnt_q <= tc_cnt_q + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_idle_flags;
    !controller_busy_flag |-> request_for_master_flag && !transfer_direction_flag;
  endproperty
  a_idle_flags: assert property (p_idle_flags) else $error("idle flags wrong");
  property p_result_entry;
    $rose(irq) && last_rw_q |-> ##[0:2] (request_for_master_flag &&
      transfer_direction_flag && controller_busy_flag);
  endproperty
  a_result_entry: assert property (p_result_entry) else $error("no result phase");
  property p_irq_hold;
    irq && !result_rd_stb && !$past(result_rd_stb) && !cmd_stb |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
  property p_busy_hold;
    controller_busy_flag && transfer_direction_flag && cmd_stb && !result_rd_stb
      |=> controller_busy_flag;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("command taken in result");
  property p_invalid;
    cmd_stb && idle && !ok_code |-> ##[1:4] irq;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid code no irq");
  property p_write_req;
    cmd_stb && idle && cmd_code == FDX_CMD_WRITE && dma_en_q |-> ##[1:4] dma_req;
  endproperty
  a_write_req: assert property (p_write_req) else $error("no write request");
  property p_no_dma;
    !dma_en_q |-> !dma_req;
  endproperty
  a_no_dma: assert property (p_no_dma) else $error("request while disabled");
  property p_tc_stop;
    tc_armed_q && tc_cnt_q >= 4'h8 |-> !dma_req;
  endproperty
  a_tc_stop: assert property (p_tc_stop) else $error("request after tc");
  property p_cfg;
    cmd_stb && idle && cmd_code == FDX_CMD_CONFIGURE |=> fifo_threshold_param_q ==
      $past(cmd_fifo_threshold_param) && fifo_disable_n_q == $past(cmd_fifo_disable_n);
  endproperty
  a_cfg: assert property (p_cfg) else $error("configure not stored");
  property p_perp;
    cmd_stb && idle && cmd_code == FDX_CMD_PERP |=>
      perpendicular_drives_q == $past(cmd_perpendicular_drive_bits);
  endproperty
  a_perp: assert property (p_perp) else $error("drive bits not stored");
  property p_seek;
    cmd_stb && idle && cmd_code == FDX_CMD_REL_SEEK |=> step_inward_q == $past(cmd_dir_in);
  endproperty
  a_seek: assert property (p_seek) else $error("step direction wrong");
endmodule
bind fdx_ctrl fdx_ctrl_properties #(.DEPTH(DEPTH)) u_props (.*);

// ---- verif/fdx_dma_model.sv ----
// Behavioural model of the system DMA controller facing the block.
// Assumes the block samples these pins through synchronisers on clk.
`timescale 1ns/1ps
module fdx_dma_model (
  // Clock and control from the testbench.
  input wire logic clk,
  input wire logic m_en,
  input wire logic m_wr,
  input wire logic m_tc,
  input wire logic [1:0] m_slow,
  // Request and read data from the block.
  input wire logic dma_req,
  input wire logic [7:0] dma_rdata,
  // Pins driven towards the block.
  output logic dma_ack_n,
  output logic dma_rd_n,
  output logic dma_wr_n,
  output logic terminal_count,
  output logic [7:0] dma_wdata,
  // Observed read bytes and write count.
  output logic got_v,
  output logic [7:0] got_d,
  output int n_wr
);
  // Strobe pins idle high, terminal count low; released bus shows a non-matching value.
  initial begin
    {dma_ack_n, dma_rd_n, dma_wr_n} = 3'h7;
    terminal_count = 1'b0;
    dma_wdata = 8'h5A;
    got_v = 1'b0;
    got_d = 8'h00;
    n_wr = 0;
  end
  // One single-byte cycle per sampled request; strobe held long enough for the sync flops.
  always begin
    @(posedge clk);
    if (m_en && dma_req === 1'b1) begin
      #1;
      dma_ack_n = 1'b0;
      if (m_wr) begin
        dma_wr_n = 1'b0;
        dma_wdata = 8'hA0 + n_wr[7:0];
        terminal_count = m_tc;
      end else begin
        dma_rd_n = 1'b0;
      end
      repeat (3 + m_slow) @(posedge clk);
      #1;
      got_d = dma_rdata;
      got_v = !m_wr;
      n_wr = n_wr + (m_wr ? 1 : 0);
      {dma_ack_n, dma_rd_n, dma_wr_n} = 3'h7;
      terminal_count = 1'b0;
      @(posedge clk);
      #1;
      got_v = 1'b0;
      // Stale requests are tolerated by waiting before looking again.
      repeat (4) @(posedge clk);
      // Write data stands until the block has taken it after the strobe end.
      dma_wdata = ~dma_wdata;
    end
  end
endmodule

// ---- verif/floppy_fifo_dma_result_control_tb.sv ----
// Testbench for the floppy FIFO, DMA and result-phase control block.
// Assumes the DMA model and the bound checker are compiled before it.
`timescale 1ns/1ps
module floppy_fifo_dma_result_control_tb import fdx_pkg::*; ;
  logic clk, rst, cmd_stb, cmd_enable_sector_count, cmd_dir_in, cmd_fifo_disable_n;
  logic cmd_dma_enable, dma_ack_n, dma_rd_n, dma_wr_n, terminal_count, dma_req, irq;
  logic disk_rd_stb, disk_wr_stb, disk_sector_end, result_rd_stb, got_v, m_en, m_wr, m_tc;
  logic request_for_master_flag, transfer_direction_flag, controller_busy_flag;
  logic step_inward_q, fifo_disable_n_q;
  logic [1:0] cmd_perpendicular_drive_bits, perpendicular_drives_q, m_slow;
  logic [2:0] cmd_size_code;
  logic [3:0] cmd_fifo_threshold_param, fifo_threshold_param_q;
  logic [4:0] cmd_code;
  logic [7:0] cmd_cylinder, cmd_final_sector_number, cmd_start_sector, cmd_special_byte_length;
  logic [7:0] dma_wdata, dma_rdata, disk_rd_data, disk_wr_data, result_data, cylinder_q;
  logic [7:0] sectors_per_track_q, got_d, thr;
  logic [15:0] seed = 16'h0054;
  logic [7:0] res_q[$], dat_q[$], wq[$];
  int n_errors = 0, num_checks = 0, cyc = 0, n_wr;
  fdx_ctrl DUT (.*);
  fdx_dma_model u_dma (.*);
  // Free-running clock.
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  task automatic cmd(input logic [4:0] c);
    cmd_code = c;
    pulse(cmd_stb);
  endtask
  task automatic push(input logic [7:0] d);
    disk_rd_data = d;
    dat_q.push_back(d);
    pulse(disk_rd_stb);
  endtask
  task automatic until_low();
    for (int i = 0; i < 600 && dma_req !== 1'b0; i++) tick();
  endtask
  // Reads offered result bytes, first trying a command that must be refused.
  task automatic drain();
    for (int i = 0; i < 120; i++) begin
      if (request_for_master_flag === 1'b1 && transfer_direction_flag === 1'b1) begin
        cmd_code = FDX_CMD_WRITE;
        pulse(cmd_stb);
        pulse(result_rd_stb);
      end
      tick();
    end
    chk({4'h0, irq, request_for_master_flag, transfer_direction_flag,
      controller_busy_flag}, 8'h04);
  endtask
  // Compares every observed result, DMA read byte and disk write byte against the oldest expectation in its queue.
  always @(posedge clk) begin
    if (result_rd_stb === 1'b1) chk(result_data, res_q.size() ? res_q.pop_front() : 8'hEE);
    if (got_v === 1'b1) chk(got_d, dat_q.size() ? dat_q.pop_front() : 8'hEE);
    if (disk_wr_stb === 1'b1) chk(disk_wr_data, wq.size() ? wq.pop_front() : 8'hEE);
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, cmd_stb, disk_rd_stb, disk_wr_stb, disk_sector_end, result_rd_stb} = 6'h20;
    {cmd_enable_sector_count, cmd_dir_in, cmd_fifo_disable_n, cmd_dma_enable} = 4'h2;
    {m_en, m_wr, m_tc, m_slow, cmd_perpendicular_drive_bits, cmd_size_code} = 10'h000;
    {cmd_code, cmd_fifo_threshold_param} = 9'h000;
    {cmd_cylinder, cmd_final_sector_number, cmd_start_sector} = 24'h0;
    {cmd_special_byte_length, disk_rd_data} = {FDX_DTL_NONE, 8'h00};
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    chk({4'h0, irq, request_for_master_flag, transfer_direction_flag,
      controller_busy_flag}, 8'h04);
    chk({dma_req, fifo_disable_n_q, 2'h0, fifo_threshold_param_q},
      {1'b0, FDX_FIFO_DIS_RST, 2'h0, FDX_THR_RST});
    thr = rnd() % 8'h0D;
    cmd_fifo_threshold_param = thr[3:0];
    cmd_fifo_disable_n = 1'b0;
    cmd(FDX_CMD_CONFIGURE);
    chk({fifo_disable_n_q, 3'h0, fifo_threshold_param_q}, thr);
    drain();
    for (int i = 0; i < 4; i++) begin
      cmd_perpendicular_drive_bits = i[1:0];
      cmd_dir_in = i[0];
      cmd(FDX_CMD_PERP);
      chk({6'h0, perpendicular_drives_q}, i[7:0]);
      drain();
      cmd(FDX_CMD_REL_SEEK);
      chk({7'h0, step_inward_q}, {7'h0, i[0]});
      drain();
    end
    cmd_enable_sector_count = 1'b1;
    cmd_special_byte_length = rnd();
    cmd(FDX_CMD_VERIFY);
    chk(sectors_per_track_q, cmd_special_byte_length);
    drain();
    {cmd_enable_sector_count, cmd_special_byte_length} = {1'b0, FDX_DTL_NONE};
    cmd(5'h1F);
    repeat (4) tick();
    chk({7'h0, irq}, 8'h01);
    cmd(FDX_CMD_READ);
    res_q.push_back(FDX_ST0_INVALID);
    cmd(FDX_CMD_SENSE_INT);
    drain();
    cmd_dma_enable = 1'b1;
    cmd(FDX_CMD_SPECIFY);
    drain();
    // Disk to host: threshold request, drain, then a short last sector.
    {cmd_cylinder, cmd_start_sector, cmd_final_sector_number} = {rnd(), 16'h0303};
    cmd_size_code = 3'h2;
    m_slow = 2'(rnd());
    cmd(FDX_CMD_READ);
    chk(cylinder_q, cmd_cylinder);
    for (int i = 0; i < 15 - thr; i++) begin
      chk({7'h0, dma_req}, 8'h00);
      push(rnd());
    end
    tick();
    chk({7'h0, dma_req}, 8'h01);
    m_en = 1'b1;
    until_low();
    repeat (10) tick();
    chk(8'(dat_q.size()), 8'h00);
    m_en = 1'b0;
    push(rnd());
    chk({7'h0, dma_req}, 8'h00);
    repeat (3) res_q.push_back(FDX_ST0_ABNORMAL);
    pulse(disk_sector_end);
    tick();
    chk({7'h0, dma_req}, 8'h01);
    m_en = 1'b1;
    drain();
    chk(8'(dat_q.size()), 8'h00);
    // Host to disk: fill, drain to threshold, then terminal count.
    for (int i = 0; i < 16; i++) wq.push_back(8'hA0 + i[7:0]);
    {m_wr, cmd_cylinder} = {1'b1, 8'hFF};
    cmd(FDX_CMD_WRITE);
    chk(cylinder_q, 8'hFF);
    until_low();
    repeat (10) tick();
    chk(8'(n_wr), 8'h10);
    m_en = 1'b0;
    for (int i = 0; i < 15 - thr; i++) begin
      chk({7'h0, dma_req}, 8'h00);
      pulse(disk_wr_stb);
    end
    tick();
    chk({7'h0, dma_req}, 8'h01);
    {m_tc, m_en} = 2'h3;
    until_low();
    repeat (20) tick();
    chk({7'h0, dma_req}, 8'h00);
    repeat (3) res_q.push_back(FDX_ST0_NORMAL);
    pulse(disk_sector_end);
    drain();
    complete_run();
  end
endmodule
